// ==== verilog/escp_pkg.sv ====
// Shared constants for the serial command port.
package escp_pkg;
   localparam int WORD_BITS = 17;
   localparam int NIB_COUNT = 4;
   localparam int NIB_BITS = 4;
   localparam int FAULT_COUNT = 4;
   localparam real WORD_TIME_US = 25.0;
   localparam real CLOCK_MHZ = 10.0;
   // Cycles allowed per word; the engine uses far fewer (about 4 per bit).
   localparam int WORD_CYCLES = int'(WORD_TIME_US * CLOCK_MHZ);
   // Word index of the first register; the APB byte address is four times the index.
   localparam logic [7:0] WIN_BASE = 8'h10;
   localparam logic [2:0] OFS_NIB0 = 3'h0;
   localparam logic [2:0] OFS_NIB1 = 3'h1;
   localparam logic [2:0] OFS_NIB2 = 3'h2;
   localparam logic [2:0] OFS_NIB3 = 3'h3;
   localparam logic [2:0] OFS_XFER = 3'h4;
   localparam logic [2:0] OFS_FAULT = 3'h5;
   localparam logic [2:0] OFS_MISC = 3'h6;
   localparam logic [2:0] OFS_CMDDONE = 3'h7;
   // Bit positions in the control and status words.
   localparam int XFER_ACTIVE_BIT = 0;
   localparam int XFER_DONE_BIT = 1;
   localparam int PAR_ERR_BIT = 2;
   localparam int CMD_DONE_BIT = 3;
   localparam int BIT17_BIT = 4;
   localparam int ATTN_BIT = 4;
   localparam int SEL_BIT = 0;
endpackage : escp_pkg

// ==== verilog/escp_port.sv ====
// Serial command and configuration/status engine with APB access and fault latches.
`timescale 1ns/1ps
module escp_port
   import escp_pkg::*;
#(
   parameter int NFAULT = FAULT_COUNT
) (
   // Clock and reset.
   input wire logic CLOCK,
   input wire logic NRST,
   // APB slave.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Host link.
   input wire logic DRIVE_SELECTED,
   input wire logic TRANSFER_REQ,
   input wire logic COMMAND_DATA,
   output logic TRANSFER_ACK,
   output logic STATUS_DATA,
   output logic COMMAND_COMPLETE,
   output logic ATTENTION,
   // Fault sources.
   input wire logic [NFAULT-1:0] FAULT_IN
);
   initial begin
      if (NFAULT < 1 || NFAULT > 8) $error("NFAULT must be 1 to 8");
      if (WORD_BITS * 4 > WORD_CYCLES) $error("word cannot fit its time budget");
   end

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RANK_B = 5'b00010,
      ST_RANK_A = 5'b00100,
      ST_ACK = 5'b01000,
      ST_WAIT_LOW = 5'b10000
   } escp_state_type;

   escp_state_type state_q;
   logic [WORD_BITS-1:0] rank_a_q; // primary_shift_rank
   logic [WORD_BITS-1:0] rank_b_q; // secondary_shift_rank
   logic [4:0] count_q;
   logic parity_q;
   logic sending_q;
   logic active_q;
   logic done_q;
   logic par_err_q;
   logic cmd_done_q;
   logic ack_q;
   logic sdata_q;
   logic [NFAULT-1:0] fault_q;
   logic attn_q;
   logic [31:0] prdata_q;

   logic wr_en;
   logic rd_en;
   logic hit;
   logic [2:0] ofs;
   logic req;
   logic last_bit;
   logic cmd_done_set;
   logic done_clr;
   logic bit_in;

   // Eight words from byte address four times the base index, word aligned.
   assign hit = PADDR[7:5] == WIN_BASE[5:3] && PADDR[1:0] == 2'b00;
   assign ofs = PADDR[4:2];
   assign wr_en = PSEL && PENABLE && PWRITE && hit;
   assign rd_en = PSEL && !PENABLE && !PWRITE;
   assign req = TRANSFER_REQ && DRIVE_SELECTED;
   assign last_bit = count_q == 5'(WORD_BITS - 1);
   assign cmd_done_set = wr_en && ofs == OFS_CMDDONE;
   assign done_clr = wr_en && ofs == OFS_XFER && PWDATA[XFER_DONE_BIT];
   // Inbound bit enters parity; outbound 17th bit is replaced by the inverse of running parity.
   assign bit_in = COMMAND_DATA;

   // The window is only 8 words; any address outside it answers with an error.
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !hit;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         prdata_q <= 32'h0;
      end else if (rd_en) begin
         prdata_q <= 32'h0;
         if (hit) begin
            unique case (ofs)
               OFS_NIB0: prdata_q[3:0] <= rank_a_q[3:0];
               OFS_NIB1: prdata_q[3:0] <= rank_a_q[7:4];
               OFS_NIB2: prdata_q[3:0] <= rank_a_q[11:8];
               OFS_NIB3: prdata_q[3:0] <= rank_a_q[15:12];
               OFS_XFER: begin
                  prdata_q[XFER_ACTIVE_BIT] <= active_q;
                  prdata_q[XFER_DONE_BIT] <= done_q;
                  prdata_q[PAR_ERR_BIT] <= par_err_q;
                  prdata_q[CMD_DONE_BIT] <= cmd_done_q;
                  prdata_q[BIT17_BIT] <= rank_a_q[WORD_BITS-1];
               end
               OFS_FAULT: prdata_q[7:0] <= 8'(fault_q);
               OFS_MISC: begin
                  prdata_q[SEL_BIT] <= DRIVE_SELECTED;
                  prdata_q[ATTN_BIT] <= attn_q;
               end
               OFS_CMDDONE: prdata_q <= 32'h0;
            endcase
         end
      end
   end
   assign PRDATA = prdata_q;

   // Serial engine: each bit takes a rank-B clock then a rank-A clock.
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         state_q <= ST_IDLE;
         rank_a_q <= '0;
         rank_b_q <= '0;
         count_q <= 5'h0;
         parity_q <= 1'b0;
         ack_q <= 1'b0;
         sdata_q <= 1'b0;
      end else begin
         if (wr_en && ofs <= OFS_NIB3) begin
            rank_a_q[ofs[1:0]*NIB_BITS +: NIB_BITS] <= PWDATA[NIB_BITS-1:0];
         end
         if (cmd_done_set) begin
            count_q <= 5'h0;
            parity_q <= 1'b0;
         end
         unique case (state_q)
            ST_IDLE: begin
               if (req && !(done_q && !sending_q)) begin
                  sdata_q <= last_bit ? ~parity_q : rank_a_q[count_q];
                  state_q <= ST_RANK_B;
               end
            end
            ST_RANK_B: begin
               rank_b_q <= {rank_a_q[WORD_BITS-2:0], bit_in};
               state_q <= ST_RANK_A;
            end
            ST_RANK_A: begin
               if (!sending_q) begin
                  rank_a_q <= rank_b_q;
                  parity_q <= parity_q ^ rank_b_q[0];
               end else begin
                  parity_q <= parity_q ^ rank_a_q[count_q];
               end
               state_q <= ST_ACK;
            end
            ST_ACK: begin
               ack_q <= 1'b1;
               count_q <= last_bit ? 5'h0 : count_q + 5'h1;
               if (last_bit) parity_q <= 1'b0;
               state_q <= ST_WAIT_LOW;
            end
            ST_WAIT_LOW: begin
               if (!TRANSFER_REQ) begin
                  ack_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Direction: a write of the done-clear bit while complete hands the word out.
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         sending_q <= 1'b0;
      end else if (done_clr && done_q) begin
         sending_q <= 1'b1;
      end else if (cmd_done_set ||
                   (state_q == ST_WAIT_LOW && !TRANSFER_REQ && count_q == 5'h0 && sending_q)) begin
         // Held until the host has taken the parity bit, so the line does not drop under it.
         sending_q <= 1'b0;
      end
   end

   // Flags; a hardware set wins over a same-cycle software clear, except parity error, which a same-cycle command-done write clears.
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         active_q <= 1'b0;
         done_q <= 1'b0;
         par_err_q <= 1'b0;
         cmd_done_q <= 1'b1;
      end else begin
         if (state_q == ST_IDLE && req) begin
            active_q <= 1'b1;
         end else if (wr_en && ofs == OFS_XFER && PWDATA[XFER_ACTIVE_BIT]) begin
            active_q <= 1'b0;
         end
         if (state_q == ST_ACK && last_bit) begin
            done_q <= 1'b1;
            if (!sending_q) par_err_q <= ~parity_q;
         end else if (cmd_done_set || done_clr) begin
            done_q <= 1'b0;
         end
         if (state_q == ST_IDLE && req && count_q == 5'h0 && !sending_q) begin
            cmd_done_q <= 1'b0;
         end else if (cmd_done_set) begin
            cmd_done_q <= 1'b1;
            par_err_q <= 1'b0;
         end
      end
   end

   // Faults: a live condition re-sets its latch even while software clears.
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         fault_q <= '0;
         attn_q <= 1'b0;
      end else begin
         if (wr_en && ofs == OFS_FAULT && PWDATA[0]) begin
            fault_q <= FAULT_IN;
         end else begin
            fault_q <= fault_q | FAULT_IN;
         end
         if (|FAULT_IN || (wr_en && ofs == OFS_FAULT && PWDATA[1])) begin
            attn_q <= 1'b1;
         end else if (wr_en && ofs == OFS_FAULT && PWDATA[0]) begin
            attn_q <= 1'b0;
         end
      end
   end

   // Host-facing outputs are registered and forced low while deselected.
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         TRANSFER_ACK <= 1'b0;
         STATUS_DATA <= 1'b0;
         COMMAND_COMPLETE <= 1'b0;
         ATTENTION <= 1'b0;
      end else begin
         TRANSFER_ACK <= ack_q && DRIVE_SELECTED;
         STATUS_DATA <= sdata_q && sending_q && DRIVE_SELECTED;
         COMMAND_COMPLETE <= cmd_done_q && DRIVE_SELECTED;
         ATTENTION <= attn_q && DRIVE_SELECTED;
      end
   end
endmodule : escp_port

// ==== dv/escp_port_sva.sv ====
// Concurrent checks on the serial command port pins.
`timescale 1ns/1ps
module escp_port_sva
   import escp_pkg::*;
#(
   parameter int NFAULT = FAULT_COUNT
) (
   // Clock and reset.
   input wire logic CLOCK,
   input wire logic NRST,
   // APB.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Host link and faults.
   input wire logic DRIVE_SELECTED,
   input wire logic TRANSFER_REQ,
   input wire logic TRANSFER_ACK,
   input wire logic STATUS_DATA,
   input wire logic COMMAND_COMPLETE,
   input wire logic ATTENTION,
   input wire logic [NFAULT-1:0] FAULT_IN
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!NRST);
   sequence req_taken;
      $rose(TRANSFER_REQ) && !TRANSFER_ACK && DRIVE_SELECTED;
   endsequence
   sequence ack_release;
      TRANSFER_ACK && !TRANSFER_REQ && DRIVE_SELECTED;
   endsequence
   AST_PREADY_NEXT: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
      else $error("ready is not a single pulse after setup");
   AST_WINDOW_ERR: assert property (PSEL && PENABLE && PREADY |->
      PSLVERR == !(PADDR[7:5] == 3'b010 && PADDR[1:0] == 2'b00))
      else $error("error response does not match the address window");
   AST_ACK_LATENCY: assert property (req_taken |-> ##[1:6] TRANSFER_ACK)
      else $error("acknowledge missing after request");
   AST_ACK_HOLD: assert property (TRANSFER_ACK && TRANSFER_REQ && DRIVE_SELECTED |=>
      TRANSFER_ACK || !DRIVE_SELECTED)
      else $error("acknowledge dropped while request high");
   AST_ACK_FALL: assert property (ack_release |-> ##[1:3] !TRANSFER_ACK)
      else $error("acknowledge stuck after request fell");
   AST_CC_DROP: assert property (req_taken and COMMAND_COMPLETE |-> ##[1:6] !COMMAND_COMPLETE)
      else $error("command complete not dropped on first request");
   AST_CC_SET: assert property (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h5C
      && DRIVE_SELECTED |-> ##[1:3] COMMAND_COMPLETE)
      else $error("command complete not set by eighth address");
   AST_ATTN: assert property ((|FAULT_IN) && DRIVE_SELECTED |->
      ##[1:3] (ATTENTION || !DRIVE_SELECTED))
      else $error("fault did not raise attention");
   AST_GATE: assert property (!DRIVE_SELECTED ##1 !DRIVE_SELECTED |->
      !TRANSFER_ACK && !COMMAND_COMPLETE && !ATTENTION && !STATUS_DATA)
      else $error("host output active while not selected");
endmodule : escp_port_sva

// ==== dv/escp_host_model.sv ====
// Host controller model driving bit-serial request/acknowledge transfers.
`timescale 1ns/1ps
module escp_host_model (
   // Link.
   input wire logic clk,
   input wire logic ack,
   input wire logic sdata,
   output logic req,
   output logic cdata
);
   initial begin
      req = 1'b0;
      cdata = 1'b0;
   end
   // Bit 0 goes first; the data line shows the inverse bit once released.
   task automatic xfer(input logic [16:0] w, output logic [16:0] rx);
      for (int i = 0; i < 17; i++) begin
         @(posedge clk);
         cdata <= w[i];
         req <= 1'b1;
         repeat (60) if (ack !== 1'b1) @(posedge clk);
         rx[i] = sdata;
         req <= 1'b0;
         cdata <= ~w[i];
         repeat (60) if (ack !== 1'b0) @(posedge clk);
      end
   endtask : xfer
endmodule : escp_host_model

// ==== dv/tb_escp_port.sv ====
// Top bench for the serial command port.
`timescale 1ns/1ps
bind escp_port escp_port_sva #(.NFAULT(NFAULT)) u_sva (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .DRIVE_SELECTED(DRIVE_SELECTED), .TRANSFER_REQ(TRANSFER_REQ), .TRANSFER_ACK(TRANSFER_ACK),
   .STATUS_DATA(STATUS_DATA), .COMMAND_COMPLETE(COMMAND_COMPLETE), .ATTENTION(ATTENTION),
   .FAULT_IN(FAULT_IN));
module tb_escp_port;
   logic clock, nrst, psel, penable, pwrite, sel, req, cdata, pready, pslverr, ack, sdata, er;
   logic cc, attn;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] fault;
   logic [16:0] rx;
   int err_count, tests_run, cyc;
   time t0;
   escp_port dut (.CLOCK(clock), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .DRIVE_SELECTED(sel), .TRANSFER_REQ(req), .COMMAND_DATA(cdata), .TRANSFER_ACK(ack),
      .STATUS_DATA(sdata), .COMMAND_COMPLETE(cc), .ATTENTION(attn), .FAULT_IN(fault));
   escp_host_model host (.clk(clock), .ack(ack), .sdata(sdata), .req(req), .cdata(cdata));
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // A hung handshake would otherwise stall the run forever.
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sel = 1'b1;
      fault = 4'h0;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      apb(1'b0, 8'h50, 32'h0);
      chk(rd, 32'h8);
      chk(cc, 1'b1);
      t0 = $time;
      host.xfer({1'b1, 16'hA5C3}, rx);
      chk(($time - t0) < 25000, 1'b1);
      chk(cc, 1'b0);
      apb(1'b0, 8'h50, 32'h0);
      chk(rd & 32'hF, 32'h3);
      // The first bit sent ends at the top of the rank; the last at bit 0.
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'hB);
      apb(1'b0, 8'h4C, 32'h0);
      chk(rd, 32'h8);
      apb(1'b1, 8'h50, 32'h1);
      apb(1'b0, 8'h50, 32'h0);
      chk(rd & 32'hF, 32'h2);
      apb(1'b1, 8'h40, 32'h5);
      apb(1'b1, 8'h44, 32'h5);
      apb(1'b1, 8'h48, 32'h5);
      apb(1'b1, 8'h4C, 32'h5);
      apb(1'b1, 8'h50, 32'h2);
      host.xfer(17'h0, rx);
      chk(^rx, 1'b1);
      chk(rx, 17'h15555);
      apb(1'b0, 8'h50, 32'h0);
      chk(rd & 32'hF, 32'h3);
      apb(1'b1, 8'h5C, 32'h0);
      apb(1'b0, 8'h50, 32'h0);
      chk(rd & 32'hF, 32'h9);
      host.xfer({1'b0, 16'hA5C3}, rx);
      apb(1'b0, 8'h50, 32'h0);
      chk(rd & 32'hF, 32'h7);
      fault <= 4'h2;
      apb(1'b0, 8'h54, 32'h0);
      fault <= 4'h4;
      chk(attn, 1'b1);
      apb(1'b1, 8'h54, 32'h1);
      apb(1'b0, 8'h54, 32'h0);
      chk(rd & 32'hF, 32'h4);
      fault <= 4'h0;
      apb(1'b1, 8'h54, 32'h1);
      apb(1'b0, 8'h54, 32'h0);
      chk(rd & 32'hF, 32'h0);
      chk(attn, 1'b0);
      apb(1'b1, 8'h54, 32'h2);
      apb(1'b0, 8'h58, 32'h0);
      chk(rd, 32'h11);
      apb(1'b0, 8'h00, 32'h0);
      chk({er, rd}, {1'b1, 32'h0});
      apb(1'b0, 8'h5C, 32'h0);
      chk({er, rd}, 33'h0);
      sel <= 1'b0;
      repeat (3) @(posedge clock);
      chk({attn, cc, ack, sdata}, 4'h0);
      close_out();
   end
endmodule : tb_escp_port
